// ==== logic/sem_core.sv ====
// Serial 64x16 nonvolatile memory: link shifter, sequencer and array
// Contract
// R1: Instruction is start bit one, two-bit opcode, six-bit address.
// R2: Array holds sixty-four sixteen-bit registers, each readable and writable.
// R3: Six address bits select one register for single-register operations.
// R4: Opcode 10 reads, 01 writes, 11 erases the addressed register.
// R5: Opcode 00 subcodes: 11 enable, 00 disable, 10 erase all, 01 write all.
// R6: Read loads the addressed word and sends a zero dummy bit first.
// R7: Each read output bit change is launched by a serial clock rise.
// R8: Output drives read data or busy status only, else released.
// R9: Programming starts disabled; enable command needed before erase or write.
// R10: Enable holds until disable command; reads work in either state.
// R11: Erase sets all bits to one; write only clears bits.
// R12: Chip select fall after erase starts the self-timed erase.
// R13: Write takes sixteen data bits; chip select fall starts programming.
// R14: With select high after start, output low while busy, high when ready.
// R15: Erase all sets every register to ones with the same timing.
// R16: Write all writes the data into every register at once.
// R17: Host keeps chip select low at least one microsecond between frames.
// R18: Host keeps serial clock period at least four microseconds.
// R19: Serial clock may idle during the programming cycle and polling.
// R20: Chip select low puts the device in standby.
// R21: Zero bits before the start bit are ignored while selected.
// R22: Each programming cycle ends within ten milliseconds, then ready shows.
`timescale 1ns/1ps
`include "sem_defs.svh"

module sem_core #(
  parameter int PROG_CYCLES = `SEM_PROG_TIME_US * `SEM_CLK_MHZ
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic serialClk,
  input  wire logic chipSel,
  input  wire logic serialIn,
  output logic      serialOut,
  output logic      serialOutEn,
  output logic      standby,
  output logic      progBusy
);
  import sem_pkg::*;

  // =====================================================================
  // Link domain: frame phase, count and read state, cleared whenever chip select is low
  sem_phase_e                 phaseReg;
  sem_phase_e                 phaseNext;
  logic [`SEM_CNT_W-1:0]      bitCntReg;
  logic [`SEM_CNT_W-1:0]      bitCntNext;
  logic [`SEM_SHIFT_W-1:0]    shiftReg;
  logic [`SEM_OPADDR_W-1:0]   opAddrReg;
  logic                       readActiveReg;
  logic                       readActiveNext;
  logic                       readBitReg;
  logic                       readBitNext;
  logic                       pendReg;
  logic                       pendNext;
  logic [`SEM_DATA_W-1:0]     readWordReg;

  wire  [`SEM_SHIFT_W-1:0]    shiftNext = {shiftReg[`SEM_SHIFT_W-2:0],
                                           serialIn};
  wire  [`SEM_CNT_W-1:0]      cntInc    = bitCntReg + `SEM_CNT_W'(1);
  wire  [1:0]                 opNow     = shiftNext[`SEM_OP_HI:`SEM_OP_LO];
  wire  [1:0]                 subNow    = shiftNext[`SEM_SUB_HI:`SEM_SUB_LO];
  wire                        needsData = (opNow == `SEM_OP_WRITE) ||
                                          ((opNow == `SEM_OP_CTRL) &&
                                           (subNow == `SEM_SUB_WRITE_ALL));
  wire                        opAddrDone = (phaseReg == PH_SHIFT) &&
                                           (cntInc == `SEM_OPADDR_BITS);
  wire  [3:0]                 readIdx   = `SEM_LAST_BIT - bitCntReg[3:0];

  always_comb begin
    phaseNext      = phaseReg;
    bitCntNext     = bitCntReg;
    readActiveNext = readActiveReg;
    readBitNext    = readBitReg;
    pendNext       = pendReg;
    unique case (phaseReg)
      PH_IDLE: begin
        if (serialIn) begin
          phaseNext  = PH_SHIFT;                                // R21
          bitCntNext = '0;                                      // R1
        end
      end
      PH_SHIFT: begin
        bitCntNext = cntInc;
        if (opAddrDone) begin
          if (opNow == `SEM_OP_READ) begin
            phaseNext      = PH_READ;                           // R4
            bitCntNext     = '0;
            readActiveNext = 1'b1;
            readBitNext    = 1'b0;                              // R6
          end else if (!needsData) begin
            phaseNext = PH_DONE;
            pendNext  = 1'b1;                                   // R5
          end
        end else if (cntInc == `SEM_FULL_BITS) begin
          phaseNext = PH_DONE;
          pendNext  = 1'b1;                                     // R13
        end
      end
      PH_READ: begin
        if (bitCntReg != `SEM_READ_BITS) begin
          readBitNext = readWordReg[readIdx];                   // R7
          bitCntNext  = cntInc;
        end
      end
      PH_DONE: begin
        pendNext = 1'b0;
      end
    endcase
  end

  always_ff @(posedge serialClk or negedge chipSel) begin
    if (!chipSel) begin
      phaseReg      <= PH_IDLE;
      bitCntReg     <= '0;
      readActiveReg <= 1'b0;
      readBitReg    <= 1'b0;
      pendReg       <= 1'b0;
    end else begin
      phaseReg      <= phaseNext;
      bitCntReg     <= bitCntNext;
      readActiveReg <= readActiveNext;
      readBitReg    <= readBitNext;
      pendReg       <= pendNext;
    end
  end

  // Data holding registers survive deselect so the core can act on them
  always_ff @(posedge serialClk) begin
    if (phaseReg == PH_SHIFT) begin
      shiftReg <= shiftNext;
    end
    if (opAddrDone) begin
      opAddrReg <= shiftNext[`SEM_OPADDR_W-1:0];                // R3
    end
  end

  // =====================================================================
  // Crossing: chip select, pending, read active and read bit
  logic [`SEM_SYNC_W-1:0]     syncS0;
  logic [`SEM_SYNC_W-1:0]     syncS1;
  logic [`SEM_SYNC_W-1:0]     syncS2;
  logic [`SEM_SYNC_W-1:0]     syncValReg;

  wire  [`SEM_SYNC_W-1:0]     syncIn = {chipSel, pendReg, readActiveReg,
                                        readBitReg};

  always_ff @(posedge core_clk) begin
    syncS0 <= syncIn;
    syncS1 <= syncS0;
    syncS2 <= syncS1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncValReg <= '0;
    end else begin
      for (int i = 0; i < `SEM_SYNC_W; i++) begin
        if (syncS1[i] == syncS2[i]) begin
          syncValReg[i] <= syncS2[i];
        end
      end
    end
  end

  wire csNow         = syncValReg[3];
  wire pendNow       = syncValReg[2];
  wire readActiveNow = syncValReg[1];
  wire readBitNow    = syncValReg[0];

  // =====================================================================
  // Core domain: command capture on chip select fall
  logic                       csPrevReg;
  logic                       readPrevReg;
  logic                       pendSeenReg;
  logic                       progEnReg;
  logic                       statusArmedReg;
  logic                       busyW;

  sem_cmd_s                   cmd;
  assign cmd.opcode = opAddrReg[`SEM_OP_HI:`SEM_OP_LO];
  assign cmd.addr   = opAddrReg[`SEM_ADDR_W-1:0];
  assign cmd.data   = shiftReg[`SEM_DATA_W-1:0];

  wire [1:0] cmdSub    = cmd.addr[`SEM_SUB_HI:`SEM_SUB_LO];
  wire       csFall    = csPrevReg && !csNow;
  wire       readRise  = readActiveNow && !readPrevReg;
  wire       execNow   = csFall && pendSeenReg && !busyW;
  wire       isCtrl    = cmd.opcode == `SEM_OP_CTRL;
  wire       isEnable  = isCtrl && (cmdSub == `SEM_SUB_ENABLE);
  wire       isDisable = isCtrl && (cmdSub == `SEM_SUB_DISABLE);
  wire       isEraseAl = isCtrl && (cmdSub == `SEM_SUB_ERASE_ALL);
  wire       isWriteAl = isCtrl && (cmdSub == `SEM_SUB_WRITE_ALL);
  wire       isErase   = cmd.opcode == `SEM_OP_ERASE;
  wire       isWrite   = cmd.opcode == `SEM_OP_WRITE;
  wire       isProgOp  = isErase || isWrite || isEraseAl || isWriteAl;
  wire       progStart = execNow && progEnReg && isProgOp;      // R9

  always_ff @(posedge core_clk) begin
    if (rst) begin
      csPrevReg   <= 1'b0;
      readPrevReg <= 1'b0;
      pendSeenReg <= 1'b0;
    end else begin
      csPrevReg   <= csNow;
      readPrevReg <= readActiveNow;
      if (csNow) begin
        pendSeenReg <= pendNow;
      end
    end
  end

  // Programming enable: cleared by reset, changed only by commands
  always_ff @(posedge core_clk) begin
    if (rst) begin
      progEnReg <= 1'b0;                                        // R9
    end else if (execNow && isEnable) begin
      progEnReg <= 1'b1;                                        // R10
    end else if (execNow && isDisable) begin
      progEnReg <= 1'b0;                                        // R10
    end
  end

  // =====================================================================
  // Storage array
  logic [`SEM_DATA_W-1:0]     memArr [`SEM_WORDS];

  // Programming can only pull bits low
  function automatic logic [`SEM_DATA_W-1:0] progMerge(
    input logic [`SEM_DATA_W-1:0] oldWord,
    input logic [`SEM_DATA_W-1:0] newWord
  );
    progMerge = oldWord & newWord;
  endfunction : progMerge

  always_ff @(posedge core_clk) begin
    if (progStart) begin
      if (isEraseAl) begin
        for (int i = 0; i < `SEM_WORDS; i++) begin
          memArr[i] <= `SEM_ERASED_WORD;                        // R15
        end
      end else if (isWriteAl) begin
        for (int i = 0; i < `SEM_WORDS; i++) begin
          memArr[i] <= progMerge(memArr[i], cmd.data);          // R16
        end
      end else if (isErase) begin
        memArr[cmd.addr] <= `SEM_ERASED_WORD;                   // R12
      end else begin
        memArr[cmd.addr] <= progMerge(memArr[cmd.addr],
                                      cmd.data);                // R11
      end
    end
  end

  // Read fetch; held stable for the link side well before its next rise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      readWordReg <= '0;
    end else if (readRise) begin
      readWordReg <= memArr[cmd.addr];                          // R2
    end
  end

  // =====================================================================
  // Self-timed cycle and status
  sem_prog_timer #(
    .CYCLES (PROG_CYCLES)                                       // R22
  ) progTimer (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (progStart),                                      // R19
    .busy     (busyW)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      statusArmedReg <= 1'b0;
    end else if (progStart) begin
      statusArmedReg <= 1'b1;                                   // R14
    end else if (csFall) begin
      statusArmedReg <= 1'b0;
    end
  end

  // =====================================================================
  // Output pins, all registered
  logic                       serialOutReg;
  logic                       serialOutEnReg;
  logic                       standbyReg;
  logic                       progBusyReg;

  wire outDrive = csNow && (readActiveNow || statusArmedReg);   // R8
  wire outValue = readActiveNow ? readBitNow : !busyW;          // R14

  always_ff @(posedge core_clk) begin
    if (rst) begin
      serialOutReg   <= 1'b0;
      serialOutEnReg <= 1'b0;
      standbyReg     <= 1'b1;
      progBusyReg    <= 1'b0;
    end else begin
      serialOutReg   <= outDrive ? outValue : 1'b0;             // R14
      serialOutEnReg <= outDrive;                               // R8
      standbyReg     <= !csNow;                                 // R20
      progBusyReg    <= busyW;
    end
  end

  assign serialOut   = serialOutReg;
  assign serialOutEn = serialOutEnReg;
  assign standby     = standbyReg;
  assign progBusy    = progBusyReg;

endmodule : sem_core

// ==== logic/sem_defs.svh ====
// Constants of the serial 64x16 nonvolatile memory block
`ifndef SEM_DEFS_SVH
`define SEM_DEFS_SVH

// =====================================================================
// Geometry
`define SEM_ADDR_W        6
`define SEM_DATA_W        16
`define SEM_WORDS         64
`define SEM_OPADDR_W      8
`define SEM_SHIFT_W       24
`define SEM_CNT_W         5
`define SEM_OPADDR_BITS   5'h08
`define SEM_FULL_BITS     5'h18
`define SEM_READ_BITS     5'h10
`define SEM_LAST_BIT      4'hF

// =====================================================================
// Field positions inside the captured operation code and address byte
`define SEM_OP_HI         7
`define SEM_OP_LO         6
`define SEM_SUB_HI        5
`define SEM_SUB_LO        4

// =====================================================================
// Operation codes and control sub-commands
`define SEM_OP_CTRL       2'h0
`define SEM_OP_WRITE      2'h1
`define SEM_OP_READ       2'h2
`define SEM_OP_ERASE      2'h3
`define SEM_SUB_DISABLE   2'h0
`define SEM_SUB_WRITE_ALL 2'h1
`define SEM_SUB_ERASE_ALL 2'h2
`define SEM_SUB_ENABLE    2'h3

// =====================================================================
// Values and timing
`define SEM_ERASED_WORD   16'hFFFF
`define SEM_SYNC_W        4
`define SEM_CLK_MHZ       50
`define SEM_PROG_TIME_US  10000

`endif

// ==== logic/sem_pkg.sv ====
// Types shared by the serial 64x16 nonvolatile memory block
`include "sem_defs.svh"

package sem_pkg;

  // =====================================================================
  // Captured instruction
  typedef struct packed {
    logic [1:0]                opcode;
    logic [`SEM_ADDR_W-1:0]    addr;
    logic [`SEM_DATA_W-1:0]    data;
  } sem_cmd_s;

  // =====================================================================
  // Phase of the serial link frame
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SHIFT,
    PH_READ,
    PH_DONE
  } sem_phase_e;

endpackage : sem_pkg

// ==== logic/sem_prog_timer.sv ====
// Self-timed programming cycle counter
`timescale 1ns/1ps

module sem_prog_timer #(
  parameter int CYCLES = 500000
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy
);
  import sem_pkg::*;

  localparam int CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] cntReg;
  logic             busyReg;

  // =====================================================================
  // Busy for exactly CYCLES clocks after the start pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cntReg  <= '0;
      busyReg <= 1'b0;
    end else if (start) begin
      cntReg  <= CNT_W'(CYCLES - 1);
      busyReg <= 1'b1;
    end else if (busyReg) begin
      if (cntReg == '0) begin
        busyReg <= 1'b0;
      end else begin
        cntReg <= cntReg - CNT_W'(1);
      end
    end
  end

  assign busy = busyReg;

endmodule : sem_prog_timer

// ==== sim/sem_core_asserts.sv ====
// Concurrent checks on the serial memory core ports
`timescale 1ns/1ps

module sem_core_asserts #(
  parameter int PROG_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic chipSel,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic standby,
  input wire logic progBusy
);
  // ==========
  // Helper logic
  logic [2:0] sckSync_reg;
  logic [2:0] csSync_reg;
  logic [3:0] age_reg;
  int         busyLen_reg;
  wire        linkEvt = (sckSync_reg[1] & ~sckSync_reg[2])
                      | (csSync_reg[1] & ~csSync_reg[2]);

  // Age since the last link clock rise or select rise
  always_ff @(posedge core_clk) begin
    sckSync_reg <= {sckSync_reg[1:0], serialClk};
    csSync_reg  <= {csSync_reg[1:0], chipSel};
    if (rst || linkEvt) begin
      age_reg <= 4'h0;
    end else if (age_reg != 4'hF) begin
      age_reg <= age_reg + 4'h1;
    end
    busyLen_reg <= (rst || !progBusy) ? 0 : busyLen_reg + 1;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ==========
  // Properties
  sequence s_statusBusy;
    serialOutEn && progBusy ##1 progBusy ##1 progBusy;
  endsequence

  a_quiet_low: assert property (!serialOutEn |-> !serialOut)
    else $error("output high while released");
  a_release_deselect: assert property ($fell(chipSel) ##1 !chipSel[*7]
    |-> !serialOutEn)
    else $error("output not released after deselect");
  a_standby_low: assert property (!chipSel[*8] |-> standby)
    else $error("no standby while deselected");
  a_standby_high: assert property (chipSel[*8] |-> !standby)
    else $error("standby while selected");
  a_start_on_fall: assert property ($rose(progBusy)
    |-> !chipSel && !$past(chipSel, 3))
    else $error("cycle started without select fall");
  a_busy_exact: assert property ($fell(progBusy)
    |-> busyLen_reg == PROG_CYCLES)
    else $error("programming cycle length wrong");
  a_busy_bound: assert property (progBusy
    |-> busyLen_reg < PROG_CYCLES)
    else $error("programming cycle too long");
  a_status_busy: assert property (s_statusBusy |-> !serialOut)
    else $error("status not low while busy");
  a_status_ready: assert property ($fell(progBusy) && serialOutEn
    |-> ##[0:3] serialOut)
    else $error("status not high when done");
  a_out_launch: assert property (serialOutEn && $past(serialOutEn)
    && $changed(serialOut) && !progBusy && !$past(progBusy, 4)
    |-> age_reg < 4'hA)
    else $error("output changed without clock rise");
endmodule : sem_core_asserts

bind sem_core sem_core_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
  .core_clk(core_clk), .rst(rst), .serialClk(serialClk),
  .chipSel(chipSel), .serialIn(serialIn), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .standby(standby), .progBusy(progBusy));

// ==== sim/sem_host_model.sv ====
// Host controller driving the serial memory link
`timescale 1ns/1ps

module sem_host_model (
  input  wire logic core_clk,
  output logic      serialClk,
  output logic      chipSel,
  output logic      serialIn,
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  logic [31:0] rdq;
  logic [31:0] enq;
  // Shared line with a pull-up: a released output reads high
  wire         doLine = serialOutEn ? serialOut : 1'b1;

  initial begin
    serialClk = 1'b0;
    chipSel   = 1'b0;
    serialIn  = 1'b0;
  end

  // ==========
  // Frame of n bits, MSB first, 4 us link clock period
  task automatic xfer(input logic [31:0] w, input int n);
    @(negedge core_clk);
    chipSel = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = w[i];
      #1000;
      serialClk = 1'b1;
      #2000;
      rdq = {rdq[30:0], doLine};
      enq = {enq[30:0], serialOutEn};
      serialClk = 1'b0;
      #1000;
    end
    chipSel = 1'b0;
    serialIn = ~serialIn;
    #1000;
  endtask : xfer

  // Raise select and wait for ready status
  task automatic poll(output logic sawBusy, output int waited);
    chipSel = 1'b1;
    #200;
    sawBusy = serialOutEn & ~doLine;
    waited = 0;
    while (!(serialOutEn && doLine) && waited < 1000) begin
      @(negedge core_clk);
      waited++;
    end
    chipSel = 1'b0;
    #1000;
  endtask : poll
endmodule : sem_host_model

// ==== sim/testbench.sv ====
// Self-checking bench for the serial 64x16 memory core
`timescale 1ns/1ps
`include "sem_defs.svh"

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  n_fail++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end

module testbench;
  localparam int PROG  = 200;
  localparam int LIMIT = 90000;
  logic        core_clk;
  logic        rst;
  logic        serialClk;
  logic        chipSel;
  logic        serialIn;
  logic        serialOut;
  logic        serialOutEn;
  logic        standby;
  logic        progBusy;
  logic        sawBusy;
  logic [15:0] r;
  logic [15:0] d;
  int          waited;
  int          a;
  int          n_fail    = 0;
  int          tests_run = 0;
  int          seed;
  int          cycles    = 0;
  int          mem [64];

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  sem_core #(.PROG_CYCLES(PROG)) i_dut (
    .core_clk(core_clk), .rst(rst), .serialClk(serialClk),
    .chipSel(chipSel), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .standby(standby), .progBusy(progBusy));

  sem_host_model i_host (
    .core_clk(core_clk), .serialClk(serialClk), .chipSel(chipSel),
    .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn));

  // ==========
  // Closing report and hang guard
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      conclude();
    end
  end

  // ==========
  // Instruction with nd data bits; optional status poll
  task automatic go(input logic [1:0] op, input int ad,
                    input logic [15:0] dt, input int nd,
                    input logic pl, input logic exp);
    logic [31:0] w;
    w = {7'h00, 1'b1, op, ad[5:0], dt} >> (16 - nd);
    i_host.xfer(w, 9 + nd);
    if (pl) begin
      i_host.poll(sawBusy, waited);
      `CHK(sawBusy, exp)
      `CHK(waited < 300, exp)
    end
  endtask : go

  // Read with z leading zeros, compared with the model
  task automatic rd(input int ad, input int z);
    logic [31:0] w;
    w = {7'h00, 1'b1, `SEM_OP_READ, ad[5:0], 16'($random(seed))};
    i_host.xfer(w, 25 + z);
    `CHK(i_host.rdq[16:0], {1'b0, mem[ad][15:0]})
    `CHK(i_host.enq[16:0], 17'h1FFFF)
  endtask : rd

  initial begin
    rst  = 1'b1;
    seed = 75;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (10) @(negedge core_clk);
    `CHK(standby, 1'b1)
    go(`SEM_OP_ERASE, 5, 16'h0000, 0, 1'b1, 1'b0);
    r = 16'($random(seed));
    go(`SEM_OP_CTRL, {`SEM_SUB_ENABLE, r[3:0]}, 16'h0000, 0, 1'b0, 1'b0);
    go(`SEM_OP_CTRL, {`SEM_SUB_ERASE_ALL, r[7:4]}, 16'h0000, 0, 1'b1,
       1'b1);
    foreach (mem[i]) mem[i] = 16'hFFFF;
    a = $unsigned($random(seed)) % 64;
    rd(a, 3);
    rd(63, 0);
    for (int k = 0; k < 2; k++) begin
      d = 16'($random(seed));
      go(`SEM_OP_WRITE, a, d, 16, 1'b1, 1'b1);
      mem[a] = mem[a] & d;
      rd(a, 0);
    end
    go(`SEM_OP_ERASE, a, 16'h0000, 0, 1'b1, 1'b1);
    mem[a] = 16'hFFFF;
    rd(a, 0);
    d = 16'($random(seed));
    go(`SEM_OP_CTRL, {`SEM_SUB_WRITE_ALL, r[11:8]}, d, 16, 1'b1,
       1'b1);
    foreach (mem[i]) mem[i] = mem[i] & d;
    rd(0, 0);
    go(`SEM_OP_CTRL, {`SEM_SUB_DISABLE, r[15:12]}, 16'h0000, 0, 1'b0,
       1'b0);
    go(`SEM_OP_WRITE, a, 16'h0000, 16, 1'b1, 1'b0);
    rd(a, 0);
    conclude();
  end
endmodule : testbench
